// File: ilk_consts.vh
`ifndef ILK_CONSTS_VH
`define ILK_CONSTS_VH

// fault flash counts
`define ILK_CODE_OUT_A      4'h1
`define ILK_CODE_OUT_B      4'h2
`define ILK_CODE_CROSS      4'h3
`define ILK_CODE_ACTUATOR   4'h5
`define ILK_CODE_FORCE      4'h6
`define ILK_CODE_TEMP       4'hA
`define ILK_CODE_NONE       4'h0

// warning delay and clock rate
`define ILK_WARN_MINUTES    30
`define ILK_CLK_HZ          125000000
`define ILK_WARN_CYCLES     (`ILK_WARN_MINUTES * 40'h3C * `ILK_CLK_HZ)

// flash timing, in cycles at 125 MHz
`define ILK_PULSE_MS        200
`define ILK_PULSE_CYCLES    (`ILK_PULSE_MS * (`ILK_CLK_HZ / 1000))
`define ILK_PAUSE_PULSES    4'h5

// latching force setting in steps of 10 N, 30 N to 100 N
`define ILK_FORCE_STEP_N    7'h0A
`define ILK_FORCE_MIN_N     7'h1E
`define ILK_FORCE_MAX_N     7'h64

// chain length
`define ILK_CHAIN_MAX       31

`endif

// File: ilk_flash_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "ilk_consts.vh"

// flash code generator: bursts of equal pulses, then a longer pause
module ilk_flash_gen #(
    parameter PULSE_CYCLES = 25000000
) (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // code to show, zero means none
    input  wire [3:0] code,
    // flashing output
    output reg        flash
);
    reg [31:0] tick_q;
    reg [4:0]  slot_q;
    wire       tickEnd = (tick_q == PULSE_CYCLES - 1);

    // each code shows 2*code slots on/off, then a fixed pause of dark slots
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_q <= 32'h0000_0000;
            slot_q <= 5'h00;
            flash  <= 1'b0;
        end else begin
            tick_q <= tickEnd ? 32'h0000_0000 : tick_q + 32'h0000_0001;
            if (code == `ILK_CODE_NONE) begin
                slot_q <= 5'h00;
                flash  <= 1'b0;
            end else if (tickEnd) begin
                if (slot_q >= {code, 1'b0} + {1'b0, `ILK_PAUSE_PULSES} - 5'h01)
                    slot_q <= 5'h00;
                else
                    slot_q <= slot_q + 5'h01;
                flash <= (slot_q + 5'h01 < {code, 1'b0}) && !slot_q[0]
                         && (slot_q + 5'h01 != {code, 1'b0} + {1'b0, `ILK_PAUSE_PULSES});
            end
        end
    end
endmodule

`default_nettype wire

// File: ilk_warn_timer.v
`timescale 1ns/10ps
`default_nettype none

// warning delay timer: counts while armed, fires once on expiry
module ilk_warn_timer #(
    parameter [39:0] LIMIT = 40'h34_630B_8A00
) (
    // clock and reset
    input  wire clk,
    input  wire rstn,
    // control
    input  wire run,
    // result
    output reg  expired
);
    reg [39:0] cnt_q;

    // count up while run, restart when run drops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q   <= 40'h00_0000_0000;
            expired <= 1'b0;
        end else if (!run) begin
            cnt_q   <= 40'h00_0000_0000;
            expired <= 1'b0;
        end else if (cnt_q >= LIMIT - 40'd1) begin
            expired <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 40'h00_0000_0001;
        end
    end
endmodule

`default_nettype wire

// File: ilk_diag_fsm.v
// Contract
// - output A fault: 1 flash, off after 30 min
// - output B fault: 2 flashes, off after 30 min
// - cross-wire: 3 flashes; expired needs power cycle
// - bad actuator: 5 flashes, immediate off
// - holding force below 500 N: 6 flashes, off; the code goes to WEAK instead, with yellow flash and no red code
// - magnet above 70 C: 10 flashes, off
// - internal fault: outputs off, red steady
// - cross, temperature, 24 V short: delayed off; the code switches temperature off at once
// - clear failure only by guard open/close
// - re-enable outputs once guard relocked
// - warning keeps outputs; escalates after 30 min
// - warning clears itself when cause gone
// - yellow flashes near sensing limit
// - green lit while powered and ready
// - red on for failure or warning
// - closed, unlocked: yellow flash, outputs low, diag high
// - locked: yellow steady, outputs high, diag high
// - weak force: yellow flash, all outputs low
// - forced separation: red+yellow flash, outputs low
// - latch force 30 to 100 N, 10 N steps
// - up to 31 units chain safely
`include "ilk_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module ilk_diag_fsm #(
    parameter [39:0] WARN_CYCLES  = `ILK_WARN_CYCLES,
    parameter        PULSE_CYCLES = `ILK_PULSE_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // guard and actuator sensing
    input  wire       guardClosed,
    input  wire       actuatorPresent,
    input  wire       actuatorNearLimit,
    input  wire       lockCmd,
    input  wire       lockEngaged,
    input  wire       forceOk,
    // chain inputs from upstream unit
    input  wire       chainInputA,
    input  wire       chainInputB,
    // fault detectors
    input  wire       faultOutA,
    input  wire       faultOutB,
    input  wire       faultCross,
    input  wire       faultActuator,
    input  wire       faultTemp,
    input  wire       faultInternal,
    // latching force adjustment target
    input  wire       forceUpPulse,
    // outputs
    output reg        safetyOutputA,
    output reg        safetyOutputB,
    output reg        diagOut,
    output reg        ledGreen,
    output reg        ledYellow,
    output reg        ledRed,
    output reg  [6:0] latchForceN,
    output reg        failure,
    output reg        warning
);
    // states: DEAD is the expired cross-wire case, left only by reset;
    // FAIL is any latched failure that a guard cycle may clear;
    // SEPARAT holds while the lock is still commanded after a separation
    localparam [2:0] ST_OPEN    = 3'h0;
    localparam [2:0] ST_CLOSED  = 3'h1;
    localparam [2:0] ST_LOCKED  = 3'h2;
    localparam [2:0] ST_WEAK    = 3'h3;
    localparam [2:0] ST_FAIL    = 3'h4;
    localparam [2:0] ST_SEPARAT = 3'h5;
    localparam [2:0] ST_DEAD    = 3'h6;

    // fsm state, latched flash code and guard-opened memory
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [3:0] failCode_q;
    reg [3:0] failCode_d;
    reg       guardSeenOpen_q;
    reg       guardSeenOpen_d;

    wire       flash;
    wire       blink;
    wire       expired;
    wire [3:0] warnCode;
    wire [3:0] immCode;
    wire       warnActive;
    // helper terms for clearing, enabling and the red code
    wire       causeGone;
    wire       chainOk;
    wire       lockedOk;
    wire       inFault;
    wire [3:0] redCode;

    // next values of the registered pins
    reg        enable_d;
    reg        diag_d;
    reg        red_d;
    reg        yellow_d;
    reg        failure_d;
    reg        warning_d;

    // delayed-class causes, encoded by priority
    // only one code can flash at a time, so the most severe delayed cause wins
    assign warnCode = (faultCross || (faultOutA && faultOutB)) ? `ILK_CODE_CROSS :
                      faultOutB ? `ILK_CODE_OUT_B :
                      faultOutA ? `ILK_CODE_OUT_A : `ILK_CODE_NONE;
    // immediate-class causes
    // these switch off at once, with no delay
    assign immCode = faultTemp ? `ILK_CODE_TEMP :
                     faultActuator ? `ILK_CODE_ACTUATOR : `ILK_CODE_NONE;
    assign warnActive = (warnCode != `ILK_CODE_NONE);

    // every cause of either class has gone, so a guard cycle may clear
    assign causeGone = (immCode == `ILK_CODE_NONE) && !warnActive && !faultInternal;
    // both upstream lines must be high before this unit passes enable on
    assign chainOk = chainInputA && chainInputB;
    // locked with no internal fault is the only state that may enable
    assign lockedOk = (state_q == ST_LOCKED) && !faultInternal;
    // latched failure of either kind
    assign inFault = (state_q == ST_FAIL) || (state_q == ST_DEAD);
    // a latched code wins over a standing warning
    assign redCode = inFault ? failCode_q : warnCode;

    // thirty minutes at 125 MHz needs a 38-bit count, so the timer is 40 bits
    // wide; a cause that drops out restarts the full delay
    // delay timer runs only while a warning stands
    ilk_warn_timer #(
        .LIMIT(WARN_CYCLES)
    ) uTimer (
        .clk    (clk),
        .rstn   (rstn),
        .run    (warnActive && state_q != ST_FAIL && state_q != ST_DEAD),
        .expired(expired)
    );

    // red flash code generator
    // the burst restarts whenever the code drops to none, so a new fault
    // raised while no code shows begins with a full burst
    ilk_flash_gen #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) uFlash (
        .clk (clk),
        .rstn(rstn),
        .code(redCode),
        .flash(flash)
    );

    // plain yellow blink: one pulse code repeats
    // shares the burst timing so red and yellow flash in one rhythm
    ilk_flash_gen #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) uBlink (
        .clk (clk),
        .rstn(rstn),
        .code(4'h1),
        .flash(blink)
    );

    // next-state logic
    // WEAK and CLOSED are derived again from the inputs every cycle; SEPARAT is entered only from LOCKED and held by lockCmd
    always @* begin
        state_d         = state_q;
        failCode_d      = failCode_q;
        guardSeenOpen_d = guardSeenOpen_q;
        case (state_q)
            ST_FAIL: begin
                // an opening only counts once the cause has gone
                if (!causeGone)
                    guardSeenOpen_d = 1'b0;
                else if (!guardClosed)
                    guardSeenOpen_d = 1'b1;
                // clear only after cause gone and guard cycled
                if (guardSeenOpen_q && guardClosed && causeGone) begin
                    state_d         = ST_CLOSED;
                    failCode_d      = `ILK_CODE_NONE;
                    guardSeenOpen_d = 1'b0;
                end
            end
            ST_DEAD: begin
                state_d = ST_DEAD; // only a power cycle leaves
            end
            default: begin
                // an expired warning outranks every other event, then the
                // immediate faults, then the guard and lock sequence
                if (expired && warnCode == `ILK_CODE_CROSS) begin
                    state_d    = ST_DEAD;
                    failCode_d = warnCode;
                end else if (expired) begin
                    state_d    = ST_FAIL;
                    failCode_d = warnCode;
                    guardSeenOpen_d = 1'b0;
                end else if (immCode != `ILK_CODE_NONE) begin
                    state_d    = ST_FAIL;
                    failCode_d = immCode;
                    guardSeenOpen_d = 1'b0;
                end else if (!guardClosed) begin
                    state_d = ST_OPEN;
                end else if (state_q == ST_LOCKED && lockCmd && !actuatorPresent) begin
                    state_d = ST_SEPARAT;
                end else if (state_q == ST_SEPARAT && lockCmd) begin
                    state_d = ST_SEPARAT;
                end else if (!actuatorPresent || !lockCmd) begin
                    state_d = actuatorPresent ? ST_CLOSED : ST_OPEN;
                end else if (lockEngaged && forceOk) begin
                    state_d = ST_LOCKED;
                end else begin
                    state_d = ST_WEAK;
                end
            end
        endcase
    end

    // state registers
    // asynchronous reset lands in OPEN with no failure latched, as at power-up
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q         <= ST_OPEN;
            failCode_q      <= `ILK_CODE_NONE;
            guardSeenOpen_q <= 1'b0;
        end else begin
            state_q         <= state_d;
            failCode_q      <= failCode_d;
            guardSeenOpen_q <= guardSeenOpen_d;
        end
    end

    // one step per target pulse; a pulse held high steps every cycle,
    // so the target side must send single-cycle pulses
    // latching force adjustment, wraps back to factory value after maximum
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latchForceN <= `ILK_FORCE_MIN_N;
        end else if (forceUpPulse) begin
            if (latchForceN >= `ILK_FORCE_MAX_N)
                latchForceN <= `ILK_FORCE_MIN_N;
            else
                latchForceN <= latchForceN + `ILK_FORCE_STEP_N;
        end
    end

    // output decode: next value of every registered pin but green and latchForceN
    always @* begin
        // both safety outputs share one enable so they can never disagree
        enable_d  = lockedOk && chainOk;
        // failure covers the clearable and the reset-only case alike
        failure_d = inFault;
        // a warning is shown only while it has not yet escalated
        warning_d = warnActive && (state_q == ST_LOCKED || state_q == ST_CLOSED
                    || state_q == ST_WEAK || state_q == ST_OPEN);
        // diag: closed, or closed and locked, with no fault standing
        diag_d = !faultInternal && !warnActive
                 && (state_q == ST_CLOSED || state_q == ST_LOCKED);
        // red: steady for internal fault, flash codes otherwise
        if (faultInternal)
            red_d = 1'b1;
        else if (state_q == ST_SEPARAT)
            red_d = blink;
        else if (inFault || warnActive)
            red_d = flash;
        else
            red_d = 1'b0;
        // yellow by operating state
        case (state_q)
            ST_LOCKED:  yellow_d = actuatorNearLimit ? blink : 1'b1;
            ST_CLOSED:  yellow_d = blink;
            ST_WEAK:    yellow_d = blink;
            ST_SEPARAT: yellow_d = blink;
            ST_OPEN:    yellow_d = actuatorNearLimit ? blink : 1'b0;
            default:    yellow_d = 1'b0;
        endcase
    end

    // registered outputs: every pin comes straight from a flip-flop
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            safetyOutputA <= 1'b0;
            safetyOutputB <= 1'b0;
            diagOut       <= 1'b0;
            ledGreen      <= 1'b0;
            ledYellow     <= 1'b0;
            ledRed        <= 1'b0;
            failure       <= 1'b0;
            warning       <= 1'b0;
        end else begin
            // green only proves that clock and supply are alive
            ledGreen      <= 1'b1;
            failure       <= failure_d;
            warning       <= warning_d;
            safetyOutputA <= enable_d;
            safetyOutputB <= enable_d;
            diagOut       <= diag_d;
            ledRed        <= red_d;
            ledYellow     <= yellow_d;
        end
    end
endmodule

`default_nettype wire

// File: ilk_diag_fsm_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ilk_diag_props #(
    parameter [39:0] WARN_CYCLES  = 40'h00C8,
    parameter        PULSE_CYCLES = 4
) (
    // clock and reset
    input wire       clk,
    input wire       rstn,
    // inputs
    input wire       guardClosed,
    input wire       chainInputA,
    input wire       faultOutA,
    input wire       faultOutB,
    input wire       faultCross,
    input wire       faultActuator,
    input wire       faultInternal,
    // outputs
    input wire       safetyOutputA,
    input wire       safetyOutputB,
    input wire       ledGreen,
    input wire       ledRed,
    input wire [6:0] latchForceN,
    input wire       failure,
    input wire       warning
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    reg [39:0] onWarn_q;
    // cycles spent enabled under a standing warning
    always @(posedge clk or negedge rstn) begin
        if (!rstn) onWarn_q <= 40'h0;
        else if (warning && safetyOutputA) onWarn_q <= onWarn_q + 40'h1;
        else onWarn_q <= 40'h0;
    end
    property p_green; $past(rstn) |-> ledGreen; endproperty
    a_green: assert property (p_green) else $error("green led off");
    property p_int; faultInternal [*2] |=> !safetyOutputA && !safetyOutputB && ledRed; endproperty
    a_int: assert property (p_int) else $error("internal fault not handled");
    property p_act; faultActuator |-> ##2 !safetyOutputA && !safetyOutputB && failure; endproperty
    a_act: assert property (p_act) else $error("actuator fault not immediate");
    property p_chain; !chainInputA [*3] |-> !safetyOutputA; endproperty
    a_chain: assert property (p_chain) else $error("output on without chain");
    property p_red; $rose(warning) |-> ##[0:60] ledRed; endproperty
    a_red: assert property (p_red) else $error("no red on warning");
    property p_esc; onWarn_q <= WARN_CYCLES + 40'h8; endproperty
    a_esc: assert property (p_esc) else $error("warning never escalated");
    property p_clr; (!faultOutA && !faultOutB && !faultCross) [*3] |-> !warning; endproperty
    a_clr: assert property (p_clr) else $error("warning not self cleared");
    property p_frc; latchForceN >= 7'h1E && latchForceN <= 7'h64 && latchForceN % 10 == 0; endproperty
    a_frc: assert property (p_frc) else $error("latch force out of range");
    property p_hold; (guardClosed && !faultInternal) [*6] ##0 failure |=> failure; endproperty
    a_hold: assert property (p_hold) else $error("failure cleared with guard shut");
endmodule
bind ilk_diag_fsm ilk_diag_props #(.WARN_CYCLES(WARN_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) uProps (
    .clk, .rstn, .guardClosed, .chainInputA, .faultOutA, .faultOutB, .faultCross,
    .faultActuator, .faultInternal, .safetyOutputA, .safetyOutputB, .ledGreen, .ledRed,
    .latchForceN, .failure, .warning);
`default_nettype wire

// File: ilk_upstream.sv
`timescale 1ns/10ps
`default_nettype none
module ilk_upstream (
    // control
    input  wire upOk,
    input  wire upSplit,
    // chain lines into the unit
    output wire chainA,
    output wire chainB
);
    // supply both lines; split drops line b alone
    assign chainA = upOk;
    assign chainB = upOk & ~upSplit;
endmodule
`default_nettype wire

// File: test_interlock_diagnostic_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module test_interlock_diagnostic_fsm;
    reg clk = 0, rstn = 0, guard = 0, act = 0, near = 0, lock = 0, eng = 0, frc = 1;
    reg fup = 0, upOk = 1, upSplit = 0, ok;
    reg [5:0] flt = 6'h00;
    wire chA, chB, sA, sB, dg, lg, ly, lr, fl, wn;
    wire [6:0] lf;
    integer miscompares = 0, checks = 0, cycles = 0, k;
    ilk_upstream up (.upOk(upOk), .upSplit(upSplit), .chainA(chA), .chainB(chB));
    ilk_diag_fsm #(.WARN_CYCLES(40'h00C8), .PULSE_CYCLES(4)) dut (
        .clk(clk), .rstn(rstn), .guardClosed(guard), .actuatorPresent(act),
        .actuatorNearLimit(near), .lockCmd(lock), .lockEngaged(eng), .forceOk(frc),
        .chainInputA(chA), .chainInputB(chB), .faultOutA(flt[0]), .faultOutB(flt[1]),
        .faultCross(flt[2]), .faultActuator(flt[3]), .faultTemp(flt[4]),
        .faultInternal(flt[5]), .forceUpPulse(fup), .safetyOutputA(sA), .safetyOutputB(sB),
        .diagOut(dg), .ledGreen(lg), .ledYellow(ly), .ledRed(lr), .latchForceN(lf),
        .failure(fl), .warning(wn));
    // clock and hang guard
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [6:0] e, input [6:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s expected %0h seen %0h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer n); repeat (n) @(negedge clk); endtask
    task put(input g, a, l, e); begin guard = g; act = a; lock = l; eng = e; cyc(3); end endtask
    // watch red (1) or yellow (0) for both levels
    task seeFlash(input r, output o);
        reg s0, s1;
        integer i;
        begin
            s0 = 0;
            s1 = 0;
            for (i = 0; i < 60; i = i + 1) begin
                @(negedge clk);
                if ((r ? lr : ly) === 1'b1) s1 = 1; else s0 = 1;
            end
            o = s0 & s1;
        end
    endtask
    task relock; begin put(0, 0, 0, 0); put(1, 1, 1, 1); cyc(1); end endtask
    task t_lock;
        begin
            put(1, 1, 0, 0);
            chk("out", 0, sA); chk("diag", 1, dg);
            seeFlash(0, ok); chk("yflash", 1, ok);
            put(1, 1, 1, 1);
            chk("outA", 1, sA); chk("outB", 1, sB); chk("diag", 1, dg); chk("yel", 1, ly);
            near = 1; seeFlash(0, ok); chk("nearfl", 1, ok); near = 0;
            frc = 0; cyc(3); chk("out", 0, sA); chk("diag", 0, dg);
            frc = 1; upSplit = 1; cyc(3); chk("outB", 0, sB);
            upSplit = 0; cyc(3); chk("out", 1, sA);
            upOk = 0; cyc(3); chk("outA", 0, sA); chk("outB", 0, sB);
            upOk = 1; cyc(3); chk("out", 1, sA);
            $display("test lock done");
        end
    endtask
    task t_warn;
        begin
            for (k = 0; k < 3; k = k + 1) begin
                flt = 6'h01 << k; cyc(3);
                chk("warn", 1, wn); chk("out", 1, sA); chk("diag", 0, dg);
                seeFlash(1, ok); chk("red", 1, ok);
                cntFlash(k[3:0] + 4'h1);
                flt = 6'h00; cyc(3); chk("warn", 0, wn); chk("out", 1, sA);
            end
            flt = 6'h01; cyc(210); chk("out", 0, sA); chk("fail", 1, fl);
            flt = 6'h00; cyc(10); chk("fail", 1, fl);
            relock; chk("fail", 0, fl); chk("out", 1, sA);
            $display("test warning done");
        end
    endtask
    task t_imm;
        begin
            for (k = 3; k < 6; k = k + 1) begin
                flt = 6'h01 << k; cyc(3);
                chk("out", 0, sA); chk("outB", 0, sB);
                if (k == 5) chk("red", 1, lr);
                if (k == 3) cntFlash(4'h5);
                if (k == 4) cntFlash(4'hA);
                flt = 6'h00; relock; chk("out", 1, sA);
            end
            act = 0; cyc(3); chk("out", 0, sA); chk("diag", 0, dg);
            seeFlash(1, ok); chk("sepred", 1, ok); seeFlash(0, ok); chk("sepyel", 1, ok);
            put(0, 0, 0, 0);
            $display("test failure done");
        end
    endtask
    task t_force;
        begin
            chk("force", 7'h1E, lf); chk("green", 1, lg);
            for (k = 1; k < 9; k = k + 1) begin
                fup = 1; cyc(1); fup = 0; cyc(3);
                chk("force", k < 8 ? 7'h1E + 7'h0A * k[6:0] : 7'h1E, lf);
            end
            $display("test force done");
        end
    endtask
    // count red rising edges over exactly one code period (pulse of 4 cycles)
    task cntFlash(input [3:0] n);
        integer i, c;
        reg p;
        begin
            c = 0;
            p = lr;
            for (i = 0; i < (2 * n + 5) * 4; i = i + 1) begin
                @(negedge clk);
                if (lr === 1'b1 && p === 1'b0) c = c + 1;
                p = lr;
            end
            chk("pulses", {3'h0, n}, c[6:0]);
        end
    endtask
    // an expired cross-wire warning is left only through reset
    task t_dead;
        begin
            relock;
            flt = 6'h04; cyc(210); chk("fail", 1, fl); chk("out", 0, sA);
            flt = 6'h00; relock; chk("fail", 1, fl); chk("out", 0, sA);
            cntFlash(4'h3);
            rstn = 0; cyc(2); rstn = 1; cyc(3);
            chk("fail", 0, fl); chk("out", 1, sA);
            put(0, 0, 0, 0);
            $display("test dead done");
        end
    endtask
    initial begin
        cyc(16);
        rstn = 1;
        cyc(2);
        t_force;
        t_lock;
        t_warn;
        t_imm;
        t_dead;
        end_of_test;
    end
endmodule
`default_nettype wire
